/* File: logic/disk_ctl_pkg.sv */
// shared constants for the disk drive channel controller
package disk_ctl_pkg;
   // ==========================================
   // channel function word layout
   localparam int FW_CLASS_HI = 15;
   localparam int FW_CLASS_LO = 13;
   localparam logic [2:0] FW_CLASS_DISK = 3'h3;
   localparam int FW_ID_HI = 12;
   localparam int FW_ID_LO = 9;
   localparam int FW_CODE_HI = 7;
   localparam int FW_CODE_LO = 0;
   // controller function groups (upper nibble of the function code)
   localparam logic [3:0] FN_STATUS = 4'h6;
   localparam logic [3:0] FN_READ0 = 4'h2;
   localparam logic [3:0] FN_READ1 = 4'h3;
   // ==========================================
   // buffers
   localparam int BUF_PARCELS = 16384;
   localparam int BUF_USED = 2048;
   localparam int XFER_SHORT = 16;
   localparam int XFER_LONG = 2048;
   // ==========================================
   // timing
   localparam int CLK_MHZ = 50;
   localparam int WCLK_DIV = 40;
   localparam int WCLK_HALF = WCLK_DIV / 2;
   localparam int RCLK_ONES = 3;
   // ==========================================
   // condition word bits
   localparam int CW_LAST_WR_DONE = 13;
   localparam int CW_WAIT_LAST_WR = 12;
   localparam int CW_STAT_OVERRUN = 11;
   localparam int CW_BUF1_PERR = 10;
   localparam int CW_BUF0_PERR = 9;
   localparam int CW_LOST_FN = 8;
   localparam int CW_BUSIN_PAR = 7;
   localparam int CW_STAT_PAR = 6;
   localparam int CW_BUSIN_PERR = 5;
   localparam int CW_STAT_PERR = 4;
   localparam int CW_DRV_ERR = 3;
   localparam int CW_DRV_BUSY = 2;
   localparam int CW_STAT_AVAIL = 1;
   localparam int CW_DRV_READY = 0;
   localparam logic [15:0] CW_RESET = 16'h0000;
   localparam logic [15:0] CW_CLR_MASK = 16'h3F3E;
endpackage

/* File: logic/parcel_fifo.sv */
// small valid/ready fifo for outbound parcels
`timescale 1ns/1ps
module parcel_fifo #(
   parameter int WIDTH = 17,
   parameter int DEPTH = 8
) (
   input wire logic clk, // clock
   input wire logic rst_sync_b, // synchronous-released reset, active low
   input wire logic [WIDTH-1:0] in_data, // write data
   input wire logic in_valid, // write request
   output logic in_ready, // space available
   output logic [WIDTH-1:0] out_data, // head word
   output logic out_valid, // head valid
   input wire logic out_ready // consumer takes head
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wp_r;
   logic [AW-1:0] rp_r;
   logic [AW:0] cnt_r;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   assign in_ready = (cnt_r != AW'(0) + (AW+1)'(DEPTH));
   assign out_valid = (cnt_r != '0);
   assign out_data = mem[rp_r];
   always_ff @(posedge clk) begin
      if (push) mem[wp_r] <= in_data;
   end
   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else begin
         if (push) wp_r <= wp_r + AW'(1);
         if (pop) rp_r <= rp_r + AW'(1);
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule // parcel_fifo

/* File: logic/disk_channel_ctl.sv */
// disk drive channel controller: function decode, buffers, cable A/B logic
`timescale 1ns/1ps
// Notes on behaviour
// - claim word when class 011 and id match
// - two buffers of 16384 parcels, 2048 used
// - fill and drain pointers toggle on completion
// - transfers 16 or 2048, judged by address
// - hold parameters until drive function issued
// - translate 8-bit function to 4-bit code
// - transmit clock is module clock over 40
// - function strobe one transmit period, rising-aligned
// - drive busy set on function accept, cleared on done
// - buffer read pulse each transmit falling edge
// - receive edge is three ones then zero
// - index and sector mark ignored
// - status read returns condition word parcel two
// - status read clears bits 13 to 8 and 5 to 1
// - bits 13 and 12 track last continued write
// - bit 11 flags overwritten unread status
// - bits 10 and 9 buffer parity errors
// - lost function rules set bit 8
// - bits 7 and 6 sampled parity levels
// - bit 5 bus-in parity error
// - bit 4 status parity error when ready
// - bit 3 drive error, bit 2 all three
// - bit 1 status available, bit 0 ready
// - odd parity valid only while ready
module disk_channel_ctl #(
   parameter logic [3:0] CTL_ID = 4'h0, // controller identifier, arbitrary default
   parameter int BUF_DEPTH = disk_ctl_pkg::BUF_PARCELS,
   parameter int FIFO_DEPTH = 8
) (
   input wire logic ref_clk, // module clock 50 MHz
   input wire logic rst_b, // async reset, active low
   input wire logic [15:0] chan_in, // channel parcel arriving at node
   input wire logic chan_fn_valid, // chan_in is a function word
   input wire logic chan_data_valid, // chan_in is a parameter or write parcel
   output logic [15:0] chan_out, // response parcel
   output logic chan_out_valid, // response parcel valid
   output logic wr_clk, // outbound transmit clock
   output logic fn_ready, // outbound function/data strobe
   output logic [3:0] fn_code, // drive function code
   output logic fn_par, // odd parity of fn_code
   output logic [15:0] bus_out, // outbound parameters and data
   output logic bus_out_par, // odd parity of bus_out
   input wire logic rd_clk, // drive receive clock, sampled
   input wire logic sd_ready, // status/data ready
   input wire logic drv_error, // drive error
   input wire logic drv_done, // drive completion
   input wire logic drv_ready, // drive ready
   input wire logic index_mark, // index/sector mark, unused
   input wire logic stat_par, // status parity
   input wire logic [15:0] bus_in, // inbound data
   input wire logic bus_in_par // inbound data parity
);
   // ==========================================
   // reset release
   logic rs1_r;
   logic rst_sync_b;
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rs1_r <= 1'b0;
         rst_sync_b <= 1'b0;
      end else begin
         rs1_r <= 1'b1;
         rst_sync_b <= rs1_r;
      end
   end

   function automatic logic odd_par16(input logic [15:0] d);
      odd_par16 = ~^d;
   endfunction

   // ==========================================
   // function word decode
   wire [7:0] fcode = chan_in[disk_ctl_pkg::FW_CODE_HI:disk_ctl_pkg::FW_CODE_LO];
   wire claim = chan_fn_valid
      && chan_in[disk_ctl_pkg::FW_CLASS_HI:disk_ctl_pkg::FW_CLASS_LO]
         == disk_ctl_pkg::FW_CLASS_DISK
      && chan_in[disk_ctl_pkg::FW_ID_HI:disk_ctl_pkg::FW_ID_LO] == CTL_ID;
   wire is_status = claim && fcode[7:4] == disk_ctl_pkg::FN_STATUS;
   wire is_rw = claim && (fcode[7:5] == 3'h1);
   wire is_write = is_rw && fcode[4];
   wire is_long = fcode[3]; // selects 2048-parcel transfer over 16
   logic busy_r;
   logic rw_pend_r;
   logic [3:0] rsh_r;
   wire redge = rsh_r == 4'b1110;
   wire drv_done_s = redge && drv_done;
   wire lost = claim && !is_status && (is_rw ? rw_pend_r : busy_r);
   wire accept = claim && !is_status && !lost;

   // ==========================================
   // drive code translation and parameter hold
   logic [3:0] code_hold_r;
   logic [15:0] parm_r;
   logic issue_pend_r;
   logic parm_wait_r;
   logic wr_mode_r;
   logic long_r;
   wire [3:0] xlate = fcode[7:4] ^ {3'h0, fcode[3]};
   always_ff @(posedge ref_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         code_hold_r <= 4'h0;
         parm_r <= 16'h0000;
         parm_wait_r <= 1'b0;
         wr_mode_r <= 1'b0;
         long_r <= 1'b0;
      end else begin
         if (accept) begin
            code_hold_r <= xlate;
            wr_mode_r <= is_write;
            long_r <= is_long;
            parm_wait_r <= 1'b1;
         end else if (parm_wait_r && chan_data_valid) begin
            parm_r <= chan_in;
            parm_wait_r <= 1'b0;
         end
      end
   end

   // ==========================================
   // transmit clock divider and strobes
   logic [5:0] div_r;
   wire rise = div_r == 6'(disk_ctl_pkg::WCLK_DIV - 1);
   wire fall = div_r == 6'(disk_ctl_pkg::WCLK_HALF - 1);
   always_ff @(posedge ref_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         div_r <= 6'h00;
      end else begin
         div_r <= rise ? 6'h00 : div_r + 6'h01;
      end
   end

   // ==========================================
   // buffers, pointers and addresses
   localparam int AW = $clog2(BUF_DEPTH);
   logic [15:0] buf0 [BUF_DEPTH];
   logic [15:0] buf1 [BUF_DEPTH];
   logic par0 [BUF_DEPTH];
   logic par1 [BUF_DEPTH];
   logic fill_ptr_r;
   logic drain_ptr_r;
   logic [AW-1:0] fill_addr_r;
   logic [AW-1:0] drain_addr_r;
   wire [AW-1:0] last_addr = long_r ? AW'(disk_ctl_pkg::XFER_LONG - 1)
                                    : AW'(disk_ctl_pkg::XFER_SHORT - 1);
   // fifo between buffer readout and cable A
   logic [16:0] fifo_out;
   logic fifo_valid;
   logic fifo_in_ready;
   logic sending_r;
   wire fetch = sending_r && fall && fifo_in_ready;
   wire [15:0] rd_word = drain_ptr_r ? buf1[drain_addr_r] : buf0[drain_addr_r];
   wire rd_pbit = drain_ptr_r ? par1[drain_addr_r] : par0[drain_addr_r];
   wire rd_perr = fetch && (odd_par16(rd_word) != rd_pbit);
   wire drain_done = fetch && drain_addr_r == last_addr;
   wire chan_fill = chan_data_valid && !parm_wait_r && wr_mode_r;
   wire drv_fill;
   wire fill_we = chan_fill || drv_fill;
   wire [15:0] fill_word = chan_fill ? chan_in : bus_in;
   wire fill_done = fill_we && fill_addr_r == last_addr;
   always_ff @(posedge ref_clk) begin
      if (fill_we && !fill_ptr_r) buf0[fill_addr_r] <= fill_word;
      if (fill_we && !fill_ptr_r) par0[fill_addr_r] <= odd_par16(fill_word);
      if (fill_we && fill_ptr_r) buf1[fill_addr_r] <= fill_word;
      if (fill_we && fill_ptr_r) par1[fill_addr_r] <= odd_par16(fill_word);
   end
   always_ff @(posedge ref_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         fill_ptr_r <= 1'b0;
         drain_ptr_r <= 1'b0;
         fill_addr_r <= '0;
         drain_addr_r <= '0;
      end else begin
         fill_addr_r <= fill_done ? '0 : fill_addr_r + AW'(fill_we);
         drain_addr_r <= drain_done ? '0 : drain_addr_r + AW'(fetch);
         if (fill_done) fill_ptr_r <= !fill_ptr_r;
         if (drain_done) drain_ptr_r <= !drain_ptr_r;
      end
   end

   parcel_fifo #(.WIDTH(17), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(ref_clk),
      .rst_sync_b(rst_sync_b),
      .in_data({1'b1, rd_word}),
      .in_valid(fetch),
      .in_ready(fifo_in_ready),
      .out_data(fifo_out),
      .out_valid(fifo_valid),
      .out_ready(rise && !issue_pend_r)
   );

   // ==========================================
   // cable A output registers
   wire send_fn = rise && issue_pend_r && !parm_wait_r;
   wire send_data = rise && !issue_pend_r && fifo_valid;
   always_ff @(posedge ref_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         issue_pend_r <= 1'b0;
         sending_r <= 1'b0;
         busy_r <= 1'b0;
         rw_pend_r <= 1'b0;
         fn_ready <= 1'b0;
         fn_code <= 4'h0;
         fn_par <= 1'b1;
         bus_out <= 16'h0000;
         bus_out_par <= 1'b1;
         wr_clk <= 1'b0;
      end else begin
         // clock edges and strobe share one register stage so they stay aligned
         if (rise) wr_clk <= 1'b1;
         else if (fall) wr_clk <= 1'b0;
         if (accept) issue_pend_r <= 1'b1;
         else if (send_fn) issue_pend_r <= 1'b0;
         if (accept && is_rw) rw_pend_r <= 1'b1;
         else if (drv_done_s) rw_pend_r <= 1'b0;
         if (accept) busy_r <= 1'b1;
         else if (drv_done_s) busy_r <= 1'b0;
         if (send_fn && wr_mode_r) sending_r <= 1'b1;
         else if (drain_done) sending_r <= 1'b0;
         if (rise) begin
            fn_ready <= send_fn || send_data;
            fn_code <= send_fn ? code_hold_r : 4'h0;
            fn_par <= send_fn ? ~^code_hold_r : 1'b1;
            if (send_fn || send_data) begin
               bus_out <= send_fn ? parm_r : fifo_out[15:0];
               bus_out_par <= odd_par16(send_fn ? parm_r : fifo_out[15:0]);
            end
         end
      end
   end

   // ==========================================
   // receive clock edge detection and capture
   logic [15:0] drv_stat_r;
   logic stat_unread_r;
   // index_mark is left unconnected on purpose
   wire stat_cap = redge && (drv_done || sd_ready);
   assign drv_fill = redge && sd_ready && !drv_done && !wr_mode_r && rw_pend_r;
   wire rdy_ok = redge && drv_ready;
   always_ff @(posedge ref_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         rsh_r <= 4'h0;
         drv_stat_r <= 16'h0000;
         stat_unread_r <= 1'b0;
      end else begin
         rsh_r <= {rsh_r[2:0], rd_clk};
         if (drv_done_s) drv_stat_r <= bus_in;
         if (drv_done_s) stat_unread_r <= 1'b1;
         else if (is_status) stat_unread_r <= 1'b0;
      end
   end

   // ==========================================
   // condition word
   logic [15:0] cw_r;
   logic [15:0] cw_set;
   logic [15:0] cw_nxt;
   logic resp2_r;
   always_comb begin
      cw_set = 16'h0000;
      cw_set[disk_ctl_pkg::CW_LAST_WR_DONE] = drv_done_s && wr_mode_r;
      cw_set[disk_ctl_pkg::CW_WAIT_LAST_WR] = send_fn && wr_mode_r;
      cw_set[disk_ctl_pkg::CW_STAT_OVERRUN] = drv_done_s && stat_unread_r;
      cw_set[disk_ctl_pkg::CW_BUF1_PERR] = rd_perr && drain_ptr_r;
      cw_set[disk_ctl_pkg::CW_BUF0_PERR] = rd_perr && !drain_ptr_r;
      cw_set[disk_ctl_pkg::CW_LOST_FN] = lost;
      cw_set[disk_ctl_pkg::CW_BUSIN_PERR] = rdy_ok && odd_par16(bus_in) != bus_in_par
         && (sd_ready || drv_done);
      cw_set[disk_ctl_pkg::CW_STAT_PERR] = rdy_ok
         && (^{sd_ready, drv_error, drv_done, drv_ready, stat_par} == 1'b0);
      cw_set[disk_ctl_pkg::CW_DRV_ERR] = redge && drv_error;
      cw_set[disk_ctl_pkg::CW_DRV_BUSY] = redge && sd_ready && drv_error && drv_done;
      cw_set[disk_ctl_pkg::CW_STAT_AVAIL] = redge && sd_ready && drv_done
         && !drv_error;
      // set wins over a clear in the same cycle
      // the clear lands as the word leaves, so the parcel carries the value before it
      cw_nxt = (resp2_r ? (cw_r & ~disk_ctl_pkg::CW_CLR_MASK) : cw_r) | cw_set;
      if (redge) begin
         cw_nxt[disk_ctl_pkg::CW_BUSIN_PAR] = bus_in_par;
         cw_nxt[disk_ctl_pkg::CW_STAT_PAR] = stat_par;
      end
      cw_nxt[disk_ctl_pkg::CW_DRV_READY] = drv_ready;
      cw_nxt[15:14] = 2'h0;
   end
   // ==========================================
   // response path
   always_ff @(posedge ref_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         cw_r <= disk_ctl_pkg::CW_RESET;
         resp2_r <= 1'b0;
         chan_out <= 16'h0000;
         chan_out_valid <= 1'b0;
      end else begin
         cw_r <= cw_nxt;
         resp2_r <= is_status;
         chan_out_valid <= claim || resp2_r;
         if (claim) chan_out <= is_status ? drv_stat_r : 16'h0000;
         else if (resp2_r) chan_out <= cw_r;
      end
   end
endmodule // disk_channel_ctl

/* File: tb/disk_ctl_props.sv */
// port-level assertions for the disk channel controller
`timescale 1ns/1ps
module disk_ctl_props #(
   parameter logic [3:0] CTL_ID = 4'h0
) (
   input wire logic ref_clk, // clock
   input wire logic rst_b, // reset, active low
   input wire logic [15:0] chan_in, // channel parcel
   input wire logic chan_fn_valid, // function word strobe
   input wire logic [15:0] chan_out, // response parcel
   input wire logic chan_out_valid, // response strobe
   input wire logic wr_clk, // transmit clock
   input wire logic fn_ready, // function strobe
   input wire logic [3:0] fn_code, // drive code
   input wire logic fn_par, // code parity
   input wire logic [15:0] bus_out, // outbound data
   input wire logic bus_out_par // outbound parity
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   // ==========
   // strobe length counter and claim decode
   logic [7:0] hi_cnt_r;
   logic [7:0] hi_cnt_nxt;
   logic claim;
   logic stat_fn;
   // wraps every transmit period so a back-to-back data stream still ends on a whole period
   assign hi_cnt_nxt = !fn_ready ? 8'h00 : (hi_cnt_r == 8'h28 ? 8'h01 : hi_cnt_r + 8'h01);
   assign claim = chan_fn_valid && chan_in[15:13] == disk_ctl_pkg::FW_CLASS_DISK
      && chan_in[12:9] == CTL_ID;
   assign stat_fn = claim && chan_in[7:4] == disk_ctl_pkg::FN_STATUS;
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) hi_cnt_r <= 8'h00;
      else hi_cnt_r <= hi_cnt_nxt;
   end
   // ==========
   // assertions
   property p_fr_len; $fell(fn_ready) |-> hi_cnt_r == 8'h28; endproperty
   a_fr_len: assert property (p_fr_len) else $error("strobe length wrong");
   property p_fr_rise; $rose(fn_ready) |-> $rose(wr_clk); endproperty
   a_fr_rise: assert property (p_fr_rise) else $error("strobe not on clock rise");
   property p_wclk; $rose(wr_clk) |-> ##20 $fell(wr_clk) ##20 $rose(wr_clk); endproperty
   a_wclk: assert property (p_wclk) else $error("transmit clock period wrong");
   property p_fn_par; fn_ready |-> fn_par == ~^fn_code; endproperty
   a_fn_par: assert property (p_fn_par) else $error("code parity wrong");
   property p_bo_par; fn_ready |-> bus_out_par == ~^bus_out; endproperty
   a_bo_par: assert property (p_bo_par) else $error("bus parity wrong");
   property p_hold; fn_ready && !$rose(wr_clk) |-> $stable(fn_code) && $stable(bus_out); endproperty
   a_hold: assert property (p_hold) else $error("code moved in strobe");
   property p_claim; claim |=> chan_out_valid; endproperty
   a_claim: assert property (p_claim) else $error("claimed word unanswered");
   property p_skip; chan_fn_valid && !claim && !$past(chan_fn_valid) |=> !chan_out_valid; endproperty
   a_skip: assert property (p_skip) else $error("foreign word answered");
   property p_stat; stat_fn |-> ##2 chan_out_valid && chan_out[15:14] == 2'h0; endproperty
   a_stat: assert property (p_stat) else $error("condition parcel wrong");
   c_fn: cover property ($rose(fn_ready));
   c_stat: cover property (stat_fn);
   c_end: cover property ($fell(fn_ready));
endmodule // disk_ctl_props

/* File: tb/drive_model.sv */
// behavioural drive on the far side of both cables
`timescale 1ns/1ps
module drive_model #(
   parameter int HALF = 80 // receive clock half period in ns
) (
   input wire logic wr_clk, // transmit clock
   input wire logic fn_ready, // function strobe
   input wire logic inject_err, // end next command with error
   input wire logic bad_par, // break parities on the done cycle
   output logic rd_clk, // free-running receive clock
   output logic sd_ready, // status ready
   output logic drv_error, // error
   output logic drv_done, // done
   output logic drv_ready, // ready
   output logic index_mark, // sector mark
   output logic stat_par, // status parity
   output logic [15:0] bus_in, // inbound data
   output logic bus_in_par // inbound parity
);
   // ==========
   // cable B
   logic pulse = 1'b0;
   logic [15:0] pat = 16'h0000;
   logic mark_r = 1'b0;
   int got = 0;
   int seen = 0;
   int wait_n = 0;
   assign drv_ready = 1'b1;
   assign index_mark = mark_r;
   assign sd_ready = pulse;
   assign drv_done = pulse;
   assign drv_error = pulse & inject_err;
   // idle lines invert each cycle; 16 bits keep even weight so parity stays put
   assign bus_in = pulse ? 16'h1230 : pat;
   assign stat_par = ~^{sd_ready, drv_error, drv_done, drv_ready} ^ (pulse & bad_par);
   assign bus_in_par = ~^bus_in ^ (pulse & bad_par);
   initial begin
      rd_clk = 1'b0;
      #7;
      forever #(HALF) rd_clk = ~rd_clk;
   end
   always @(negedge wr_clk) begin
      if (fn_ready === 1'b1) got++;
   end
   always @(posedge rd_clk) begin
      pat <= ~pat;
      pulse <= 1'b0;
      mark_r <= ~mark_r;
      if (got != seen) begin
         wait_n <= wait_n + 1;
         if (wait_n == 5) begin
            seen <= got;
            wait_n <= 0;
            pulse <= 1'b1;
         end
      end
   end
endmodule // drive_model

/* File: tb/tb_top.sv */
// self-checking bench for the disk channel controller
`timescale 1ns/1ps
bind disk_channel_ctl disk_ctl_props #(.CTL_ID(CTL_ID)) props (.ref_clk(ref_clk),
   .rst_b(rst_b), .chan_in(chan_in), .chan_fn_valid(chan_fn_valid), .chan_out(chan_out),
   .chan_out_valid(chan_out_valid), .wr_clk(wr_clk), .fn_ready(fn_ready), .fn_code(fn_code),
   .fn_par(fn_par), .bus_out(bus_out), .bus_out_par(bus_out_par));
module tb_top;
   logic ref_clk = 1'b0, rst_b = 1'b0, chan_fn_valid = 1'b0, chan_data_valid = 1'b0;
   logic inject_err = 1'b0, bad_par = 1'b0;
   logic [15:0] chan_in = 16'h0000;
   logic [15:0] chan_out, bus_out, bus_in, last_bo;
   logic [3:0] fn_code, last_code;
   logic chan_out_valid, wr_clk, fn_ready, fn_par, bus_out_par, rd_clk, sd_ready, last_par;
   logic drv_error, drv_done, drv_ready, index_mark, stat_par, bus_in_par;
   logic [15:0] rsp[$];
   logic [15:0] bo_q[$];
   int fail_count = 0;
   int total_checks = 0;
   int cyc = 0;
   always #10 ref_clk = ~ref_clk;
   disk_channel_ctl dut (.ref_clk(ref_clk), .rst_b(rst_b), .chan_in(chan_in),
      .chan_fn_valid(chan_fn_valid), .chan_data_valid(chan_data_valid), .chan_out(chan_out),
      .chan_out_valid(chan_out_valid), .wr_clk(wr_clk), .fn_ready(fn_ready), .fn_code(fn_code),
      .fn_par(fn_par), .bus_out(bus_out), .bus_out_par(bus_out_par), .rd_clk(rd_clk),
      .sd_ready(sd_ready), .drv_error(drv_error), .drv_done(drv_done), .drv_ready(drv_ready),
      .index_mark(index_mark), .stat_par(stat_par), .bus_in(bus_in), .bus_in_par(bus_in_par));
   drive_model drv (.wr_clk(wr_clk), .fn_ready(fn_ready), .inject_err(inject_err),
      .bad_par(bad_par), .rd_clk(rd_clk), .sd_ready(sd_ready), .drv_error(drv_error),
      .drv_done(drv_done), .drv_ready(drv_ready), .index_mark(index_mark),
      .stat_par(stat_par), .bus_in(bus_in), .bus_in_par(bus_in_par));
   // ==========
   // monitors; sampled mid-cycle so registered outputs have settled
   always @(negedge ref_clk) begin
      cyc++;
      if (chan_out_valid === 1'b1) rsp.push_back(chan_out);
      if (cyc == 6000) begin
         fail_count++;
         results();
      end
   end
   always @(negedge wr_clk) begin
      if (fn_ready === 1'b1) begin
         last_code = fn_code;
         last_par = fn_par;
         last_bo = bus_out;
         bo_q.push_back(bus_out);
      end
   end
   // ==========
   // tasks
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic send(input logic [15:0] w, input logic data);
      @(negedge ref_clk);
      chan_in = w;
      chan_fn_valid = !data;
      chan_data_valid = data;
      @(negedge ref_clk);
      chan_fn_valid = 1'b0;
      chan_data_valid = 1'b0;
      repeat (4) @(negedge ref_clk);
   endtask
   task automatic stat(input logic [15:0] exp);
      rsp.delete();
      send(16'h6060, 1'b0);
      check(16'(rsp.size()), 16'h0002);
      check(rsp[1], exp);
   endtask
   task automatic drvfn(input logic [7:0] code, input logic [15:0] prm);
      send({8'h60, code}, 1'b0);
      send(prm, 1'b1);
   endtask
   task automatic wait_done;
      for (int i = 0; i < 600 && drv_done !== 1'b1; i++) @(negedge ref_clk);
      repeat (12) @(negedge ref_clk);
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // ==========
   // main sequence
   initial begin
      repeat (16) @(negedge ref_clk);
      check({15'h0000, chan_out_valid}, 16'h0000);
      check({12'h000, fn_ready, fn_par, bus_out_par, wr_clk}, 16'h0006);
      rst_b = 1'b1;
      // the receive edge detector needs a full receive period before bits 7 and 6 are valid
      repeat (20) @(negedge ref_clk);
      stat(16'h0081);
      rsp.delete();
      send(16'h4060, 1'b0);
      send(16'h6260, 1'b0);
      send(16'hE060, 1'b0);
      check(16'(rsp.size()), 16'h0000);
      send(16'h6160, 1'b0);
      check(16'(rsp.size()), 16'h0002);
      drvfn(8'h10, 16'hA5A5);
      send(16'h6010, 1'b0);
      stat(16'h0181);
      wait_done();
      check({12'h000, last_code}, 16'h0001);
      check(last_bo, 16'hA5A5);
      stat(16'h0083);
      stat(16'h0081);
      drvfn(8'h10, 16'h0F0F);
      wait_done();
      drvfn(8'h10, 16'h0F0F);
      wait_done();
      stat(16'h0883);
      inject_err = 1'b1;
      bad_par = 1'b1;
      drvfn(8'h58, 16'h0000);
      wait_done();
      inject_err = 1'b0;
      bad_par = 1'b0;
      check({11'h000, last_par, last_code}, 16'h0004);
      stat(16'h00BD);
      // short write: parameter, a refused second write, then 16 parcels via buffer and fifo
      bo_q.delete();
      drvfn(8'h30, 16'h5A00);
      send(16'h6030, 1'b0);
      for (int i = 1; i <= 16; i++) begin
         send(16'h5A00 + 16'(i), 1'b1);
      end
      repeat (700) @(negedge ref_clk);
      check(16'(bo_q.size()), 16'h0011);
      check(bo_q[0], 16'h5A00);
      for (int i = 1; i <= 16; i++) begin
         check(bo_q[i], 16'h5A00 + 16'(i));
      end
      rsp.delete();
      send(16'h6060, 1'b0);
      check(rsp[1] & 16'h1100, 16'h1100);
      results();
   end
endmodule // tb_top
